/* File: rtl/intc_pkg.sv */
/*
 * constants, register map and carrier types of the interrupt vector status unit.
 * assumes a single clock domain shared with the core and the peripherals.
 */
`default_nettype none
package intc_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_SRC      = 8;
    localparam int NUM_TRAP     = 4;
    localparam int NUM_CAND     = NUM_SRC + NUM_TRAP;
    localparam int STACK_DEPTH  = 8;
    localparam int DATA_W       = 32;
    localparam int ADDR_W       = 8;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_VECTOR_STATUS = 8'h00;
    localparam logic [7:0] OFF_CONTROL_ONE   = 8'h01;
    localparam logic [7:0] OFF_FLAGS         = 8'h02;
    localparam logic [7:0] OFF_ENABLES       = 8'h03;
    localparam logic [7:0] OFF_PRIORITIES    = 8'h04;
    localparam logic [7:0] OFF_STATUS_LOW    = 8'h05;
    localparam logic [7:0] OFF_TIMED_DISABLE = 8'h06;
    localparam logic [7:0] OFF_EVENT_STATUS  = 8'h07;
    localparam logic [7:0] OFF_EVENT_MASK    = 8'h08;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_REQ_UNACK   = 15;
    localparam int BIT_RESERVED    = 14;
    localparam int BIT_VECTOR_HOLD_SELECT       = 13;
    localparam int LSB_ILR         = 8;
    localparam int BIT_NEST_DIS    = 15;
    localparam int LSB_IPL_IN_SLB  = 5;
    localparam int PRIO_W          = 3;
    localparam int TIMED_DISABLE_INSTR_W          = 14;
    localparam int EVT_ACK         = 0;
    localparam int EVT_TRAP        = 1;
    localparam int EVT_RETURN      = 2;
    localparam int EVT_W           = 3;

    // ----------------------------------------------------------------
    // reset values and levels
    // ----------------------------------------------------------------
    localparam logic [2:0] PRIO_RESET     = 3'h4;
    localparam logic [3:0] LEVEL_USER_MAX = 4'h7;
    localparam logic [3:0] LEVEL_TRAP_MIN = 4'h8;
    localparam logic [3:0] LEVEL_TIMED_DISABLE_INSTR_MAX = 4'h6;
    localparam logic [6:0] CODE_USER_BASE = 7'h04;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic       valid;
        logic [3:0] level;
        logic [6:0] code;
    } core_req_type;

    typedef struct packed {
        logic       ipl3;
        logic [7:0] slb;
    } frame_type;
endpackage
`default_nettype wire

/* File: rtl/interrupt_vector_status_unit.sv */
/*
 * interrupt priority arbiter and vector status reporting for one core.
 * assumes source and trap events, ack and return strobes come from logic on clk;
 * the register port is a plain strobe bus with read data one cycle later.
 */
// The address map and the address-and-strobe port were chosen for this implementation.
// Notes on behaviour
// - status bit 15 reads one while an enabled source of nonzero priority not held off by the timed disable, or a trap request, is pending, acknowledged or not.
// - with vector hold set the vector field shows the best pending request.
// - with vector hold clear the vector field shows the last acknowledged request.
// - a read-only four-bit field shows the cpu priority level, all ones meaning fifteen.
// - the vector field holds the vector number minus eight.
// - unimplemented bits read zero and the reserved bit is held at zero.
// - with nesting disabled no user request nests inside one being serviced.
// - every user source priority resets to level four.
// - a source requests only while its enable bit is set.
// - a source flag stays set until software clears it, so service repeats.
// - a return from interrupt in a cycle without an acknowledge restores the saved status low byte and priority level for up to eight nested levels.
// - a trap flag stays set until software clears it, so the trap repeats.
// - cpu priority seven written into the status low byte blocks all user requests.
// - the status low byte alone masks levels up to seven; trap levels eight to eleven are masked only while ipl3 is set by a trap in service.
// - the timed disable masks levels one to six for a count and leaves seven alone.
`default_nettype none
module interrupt_vector_status_unit (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire intc_pkg::bus_req_type         bus_req,
    output logic [intc_pkg::DATA_W-1:0]        bus_rdata,
    input  wire logic [intc_pkg::NUM_SRC-1:0]  src_event,
    input  wire logic [intc_pkg::NUM_TRAP-1:0] trap_event,
    output intc_pkg::core_req_type             core_req,
    input  wire logic                          core_ack,
    input  wire logic                          core_return,
    output logic                               irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [intc_pkg::NUM_SRC-1:0]          flag_reg;
    logic [intc_pkg::NUM_SRC-1:0]          enable_reg;
    logic [intc_pkg::NUM_SRC*3-1:0]        prio_reg;
    logic [intc_pkg::NUM_TRAP-1:0]         trap_reg;
    logic                                  nest_dis_reg;
    logic                                  vector_hold_select_reg;
    logic [7:0]                            slb_reg;
    logic                                  ipl3_reg;
    logic [intc_pkg::TIMED_DISABLE_INSTR_W-1:0]           timed_disable_instr_reg;
    logic [6:0]                            last_code_reg;
    intc_pkg::frame_type                   stack_reg [intc_pkg::STACK_DEPTH];
    logic [3:0]                            depth_reg;
    logic [intc_pkg::EVT_W-1:0]            evt_reg;
    logic [intc_pkg::EVT_W-1:0]            mask_reg;
    intc_pkg::core_req_type                core_req_reg;
    logic [intc_pkg::DATA_W-1:0]           rdata_reg;
    logic                                  irq_reg;

    logic [3:0]                            ipl;
    logic                                  wr_hit_flags;
    logic                                  wr_hit_ctl;
    logic                                  rd_evt;
    logic                                  ack_taken;
    logic                                  ret_taken;
    logic [3:0]                            cand_level [intc_pkg::NUM_CAND];
    logic [intc_pkg::NUM_CAND-1:0]         cand_valid;
    logic                                  best_valid;
    logic [3:0]                            best_level;
    logic [6:0]                            best_code;
    logic                                  forward;
    logic [intc_pkg::EVT_W-1:0]            evt_set;
    logic [intc_pkg::DATA_W-1:0]           rdata_next;

    assign ipl          = {ipl3_reg, slb_reg[intc_pkg::LSB_IPL_IN_SLB +: 3]};
    assign wr_hit_flags = bus_req.wr && bus_req.addr == intc_pkg::OFF_FLAGS;
    assign wr_hit_ctl   = bus_req.wr && bus_req.addr == intc_pkg::OFF_CONTROL_ONE;
    assign rd_evt       = bus_req.rd && bus_req.addr == intc_pkg::OFF_EVENT_STATUS;
    assign ack_taken    = core_ack && core_req_reg.valid;
    assign ret_taken    = core_return && depth_reg != 4'h0 && !ack_taken;

    // ----------------------------------------------------------------
    // candidates: traps first, then user sources
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < intc_pkg::NUM_CAND; g++) begin : g_cand
            if (g < intc_pkg::NUM_TRAP) begin : g_trap
                assign cand_level[g] = intc_pkg::LEVEL_TRAP_MIN + 4'(g);
                assign cand_valid[g] = trap_reg[g];
            end else begin : g_user
                localparam int S = g - intc_pkg::NUM_TRAP;
                logic [2:0] p;
                logic       timed_disable_instr_block;
                assign p            = prio_reg[S*3 +: 3];
                assign cand_level[g] = {1'b0, p};
                assign timed_disable_instr_block   = timed_disable_instr_reg != '0
                                      && {1'b0, p} <= intc_pkg::LEVEL_TIMED_DISABLE_INSTR_MAX;
                assign cand_valid[g] = flag_reg[S] && enable_reg[S]
                                       && p != 3'h0 && !timed_disable_instr_block;
            end
        end
    endgenerate

    // highest level wins, lowest code on a tie
    always_comb begin
        best_valid = 1'b0;
        best_level = 4'h0;
        best_code  = 7'h00;
        for (int i = intc_pkg::NUM_CAND - 1; i >= 0; i--) begin
            if (cand_valid[i] && (!best_valid || cand_level[i] >= best_level)) begin
                best_valid = 1'b1;
                best_level = cand_level[i];
                best_code  = 7'(i);
            end
        end
    end

    always_comb begin
        forward = best_valid && best_level > ipl;
        if (nest_dis_reg && depth_reg != 4'h0 && best_level <= intc_pkg::LEVEL_USER_MAX) begin
            forward = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // request to the core
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_req_reg <= '0;
        end else begin
            core_req_reg.valid <= forward && !ack_taken && !core_return;
            core_req_reg.level <= best_level;
            core_req_reg.code  <= best_code;
        end
    end

    // ----------------------------------------------------------------
    // source flags, enables, priorities
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= '0;
        end else if (wr_hit_flags) begin
            flag_reg <= bus_req.wdata[intc_pkg::NUM_SRC-1:0] | src_event;
        end else begin
            flag_reg <= flag_reg | src_event;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= '0;
        end else if (bus_req.wr && bus_req.addr == intc_pkg::OFF_ENABLES) begin
            enable_reg <= bus_req.wdata[intc_pkg::NUM_SRC-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_reg <= {intc_pkg::NUM_SRC{intc_pkg::PRIO_RESET}};
        end else if (bus_req.wr && bus_req.addr == intc_pkg::OFF_PRIORITIES) begin
            prio_reg <= bus_req.wdata[intc_pkg::NUM_SRC*3-1:0];
        end
    end

    // ----------------------------------------------------------------
    // control one: nesting disable and trap flags; vector status: vector hold select
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nest_dis_reg <= 1'b0;
            trap_reg     <= '0;
        end else if (wr_hit_ctl) begin
            nest_dis_reg <= bus_req.wdata[intc_pkg::BIT_NEST_DIS];
            trap_reg     <= bus_req.wdata[intc_pkg::NUM_TRAP-1:0] | trap_event;
        end else begin
            trap_reg     <= trap_reg | trap_event;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_hold_select_reg <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == intc_pkg::OFF_VECTOR_STATUS) begin
            vector_hold_select_reg <= bus_req.wdata[intc_pkg::BIT_VECTOR_HOLD_SELECT];
        end
    end

    // ----------------------------------------------------------------
    // cpu priority, nesting stack, return, timed disable and last acknowledged code
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slb_reg   <= 8'h00;
            ipl3_reg  <= 1'b0;
            depth_reg <= 4'h0;
        end else if (ack_taken) begin
            depth_reg <= depth_reg + 4'h1;
            ipl3_reg  <= core_req_reg.level[3];
            slb_reg[intc_pkg::LSB_IPL_IN_SLB +: 3] <= core_req_reg.level[2:0];
        end else if (ret_taken) begin
            depth_reg <= depth_reg - 4'h1;
            ipl3_reg  <= stack_reg[3'(depth_reg - 4'h1)].ipl3;
            slb_reg   <= stack_reg[3'(depth_reg - 4'h1)].slb;
        end else if (bus_req.wr && bus_req.addr == intc_pkg::OFF_STATUS_LOW) begin
            slb_reg   <= bus_req.wdata[7:0];
        end
    end

    // stack entries need no reset: only those below the depth are read
    always_ff @(posedge clk) begin
        if (ack_taken) begin
            stack_reg[depth_reg[2:0]] <= '{ipl3: ipl3_reg, slb: slb_reg};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timed_disable_instr_reg <= '0;
        end else if (bus_req.wr && bus_req.addr == intc_pkg::OFF_TIMED_DISABLE) begin
            timed_disable_instr_reg <= bus_req.wdata[intc_pkg::TIMED_DISABLE_INSTR_W-1:0];
        end else if (timed_disable_instr_reg != '0) begin
            timed_disable_instr_reg <= timed_disable_instr_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_code_reg <= 7'h00;
        end else if (ack_taken) begin
            last_code_reg <= core_req_reg.code;
        end
    end

    // ----------------------------------------------------------------
    // event status, mask and interrupt line
    // ----------------------------------------------------------------
    assign evt_set = {ret_taken, |trap_event, ack_taken};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_reg <= '0;
        end else if (rd_evt) begin
            evt_reg <= evt_set;
        end else begin
            evt_reg <= evt_reg | evt_set;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= '0;
        end else if (bus_req.wr && bus_req.addr == intc_pkg::OFF_EVENT_MASK) begin
            mask_reg <= bus_req.wdata[intc_pkg::EVT_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(evt_reg & mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb begin
        rdata_next = '0;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                intc_pkg::OFF_VECTOR_STATUS: begin
                    rdata_next[intc_pkg::BIT_REQ_UNACK] = best_valid;
                    rdata_next[intc_pkg::BIT_VECTOR_HOLD_SELECT]     = vector_hold_select_reg;
                    rdata_next[intc_pkg::LSB_ILR +: 4]  = ipl;
                    rdata_next[6:0] = vector_hold_select_reg ? best_code : last_code_reg;
                end
                intc_pkg::OFF_CONTROL_ONE: begin
                    rdata_next[intc_pkg::BIT_NEST_DIS]   = nest_dis_reg;
                    rdata_next[intc_pkg::NUM_TRAP-1:0]   = trap_reg;
                end
                intc_pkg::OFF_FLAGS:         rdata_next[intc_pkg::NUM_SRC-1:0] = flag_reg;
                intc_pkg::OFF_ENABLES:       rdata_next[intc_pkg::NUM_SRC-1:0] = enable_reg;
                intc_pkg::OFF_PRIORITIES:    rdata_next[intc_pkg::NUM_SRC*3-1:0] = prio_reg;
                intc_pkg::OFF_STATUS_LOW:    rdata_next[7:0] = slb_reg;
                intc_pkg::OFF_TIMED_DISABLE: rdata_next[intc_pkg::TIMED_DISABLE_INSTR_W-1:0] = timed_disable_instr_reg;
                intc_pkg::OFF_EVENT_STATUS:  rdata_next[intc_pkg::EVT_W-1:0] = evt_reg;
                intc_pkg::OFF_EVENT_MASK:    rdata_next[intc_pkg::EVT_W-1:0] = mask_reg;
                default:                     rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign bus_rdata = rdata_reg;
    assign core_req  = core_req_reg;
    assign irq       = irq_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_fwd_above_ipl: assert property (
        @(posedge clk) disable iff (!rst_n)
        core_req_reg.valid |-> core_req_reg.level > $past(ipl))
        else $error("request forwarded at or below cpu priority");

    a_trap_never_masked: assert property (
        @(posedge clk) disable iff (!rst_n)
        (trap_reg != '0 && ipl < intc_pkg::LEVEL_TRAP_MIN && !ack_taken && !core_return)
        |=> core_req_reg.valid)
        else $error("pending trap not forwarded");

    a_ipl7_blocks_user: assert property (
        @(posedge clk) disable iff (!rst_n)
        core_req_reg.valid && core_req_reg.level <= intc_pkg::LEVEL_USER_MAX
        |-> $past(ipl) < intc_pkg::LEVEL_USER_MAX)
        else $error("user request passed cpu priority seven");

    a_timed_disable_instr_masks_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        core_req_reg.valid && $past(timed_disable_instr_reg) != '0
        |-> core_req_reg.level > intc_pkg::LEVEL_TIMED_DISABLE_INSTR_MAX)
        else $error("timed disable let a low level through");

    a_nest_blocked: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(nest_dis_reg) && $past(depth_reg) != 4'h0 && core_req_reg.valid
        |-> core_req_reg.level >= intc_pkg::LEVEL_TRAP_MIN)
        else $error("user request nested while nesting disabled");

    a_flag_sticky: assert property (
        @(posedge clk) disable iff (!rst_n)
        flag_reg != '0 && !wr_hit_flags |=> (flag_reg & $past(flag_reg)) == $past(flag_reg))
        else $error("source flag dropped without a write");

    a_trap_sticky: assert property (
        @(posedge clk) disable iff (!rst_n)
        trap_reg != '0 && !wr_hit_ctl |=> (trap_reg & $past(trap_reg)) == $past(trap_reg))
        else $error("trap flag dropped without a write");

    // check helper: cpu priority held before the outermost acknowledge
    logic [3:0]                            outer_ipl_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outer_ipl_reg <= 4'h0;
        end else if (ack_taken && depth_reg == 4'h0) begin
            outer_ipl_reg <= ipl;
        end
    end

    a_return_restores: assert property (
        @(posedge clk) disable iff (!rst_n)
        ret_taken && depth_reg == 4'h1 |=> ipl == outer_ipl_reg)
        else $error("return did not restore cpu priority");

    a_enable_gates: assert property (
        @(posedge clk) disable iff (!rst_n)
        core_req_reg.valid && core_req_reg.code >= intc_pkg::CODE_USER_BASE
        |-> |($past(enable_reg) & (8'h01 << 3'(core_req_reg.code - intc_pkg::CODE_USER_BASE))))
        else $error("disabled source requested");

    a_vector_field: assert property (
        @(posedge clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == intc_pkg::OFF_VECTOR_STATUS && vector_hold_select_reg
        |=> bus_rdata[6:0] == $past(best_code) && bus_rdata[intc_pkg::BIT_RESERVED] == 1'b0)
        else $error("vector field wrong with hold set");
endmodule
`default_nettype wire

/* File: bench/core_model.sv */
/*
 * partner model of the processor core: acknowledges requests and returns.
 * assumes the unit's clock and reset; the bench commands each return.
 */
`default_nettype none
module core_model (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire intc_pkg::core_req_type core_req,
    input  wire logic                   ack_en,
    input  wire logic                   slow,
    input  wire logic                   ret_go,
    output logic                        core_ack,
    output logic                        core_return
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_cnt;
    // ----------------------------------------------------------------
    // acknowledge 1 or 5 cycles after the request appears, one cycle pulse per request
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_ack <= 1'b0;
            wait_cnt <= 3'h0;
        end else if (core_ack || !core_req.valid || !ack_en) begin
            core_ack <= 1'b0;
            wait_cnt <= 3'h0;
        end else if (wait_cnt == (slow ? 3'h4 : 3'h0)) begin
            core_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_return <= 1'b0;
        end else begin
            core_return <= ret_go;
        end
    end
endmodule
`default_nettype wire

/* File: bench/interrupt_vector_status_unit_test.sv */
/*
 * self-checking bench of the interrupt vector status unit.
 * assumes rtl/intc_pkg.sv, the unit and bench/core_model.sv compiled first.
 */
`default_nettype none
module interrupt_vector_status_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk;
    logic                  rst_n;
    intc_pkg::bus_req_type bus_req;
    logic [31:0]           bus_rdata;
    logic [7:0]            src_event;
    logic [3:0]            trap_event;
    intc_pkg::core_req_type core_req;
    logic                  core_ack;
    logic                  core_return;
    logic                  irq;
    logic                  ack_en;
    logic                  slow;
    logic                  ret_go;
    logic [31:0]           rdv;
    int                    n_errors;
    int                    n_tests;

    interrupt_vector_status_unit dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .src_event(src_event), .trap_event(trap_event),
        .core_req(core_req), .core_ack(core_ack), .core_return(core_return), .irq(irq));
    core_model core (.clk(clk), .rst_n(rst_n), .core_req(core_req), .ack_en(ack_en),
        .slow(slow), .ret_go(ret_go), .core_ack(core_ack), .core_return(core_return));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) bus_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) bus_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) bus_req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk) bus_req <= '0;
        #1 d = bus_rdata;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(nm, d, exp);
    endtask
    task automatic ev(input logic [7:0] s, input logic [3:0] t);
        @(posedge clk) {src_event, trap_event} <= {s, t};
        @(posedge clk) {src_event, trap_event} <= '0;
    endtask
    task automatic wait_ack();
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++) begin
            @(posedge clk);
            #1 seen = (core_ack === 1'b1);
        end
        chk("ack", 32'(seen), 32'h1);
    endtask
    task automatic ret();
        @(posedge clk) ret_go <= 1'b1;
        @(posedge clk) ret_go <= 1'b0;
    endtask
    task automatic chk_req(input logic v, input logic [3:0] lvl);
        chk("valid", 32'(core_req.valid), 32'(v));
        if (v) chk("level", 32'(core_req.level), 32'(lvl));
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic s_reset();
        rd_chk("prio reset", 8'h04, 32'h00924924);
        rd_chk("status reset", 8'h00, 32'h0);
        wr(8'h00, 32'hffffffff);
        rd_chk("status writable", 8'h00, 32'h00002000);
        wr(8'h00, 32'h0);
        ev(8'hff, 4'h0);
        cyc(3);
        chk_req(1'b0, 4'h0);
        rd_chk("flags", 8'h02, 32'h000000ff);
        wr(8'h02, 32'h0);
    endtask
    task automatic s_service();
        @(posedge clk) ack_en <= 1'b1;
        wr(8'h03, 32'h1);
        ev(8'h01, 4'h0);
        wait_ack();
        chk_req(1'b1, 4'h4);
        chk("code", 32'(core_req.code), 32'(intc_pkg::CODE_USER_BASE));
        cyc(2);
        rd_chk("after ack", 8'h00, 32'h00008404);
        rd_chk("ipl raised", 8'h05, 32'h80);
        wr(8'h01, 32'h00008000);
        wr(8'h04, 32'h00924926);
        cyc(2);
        chk_req(1'b0, 4'h0);
        wr(8'h04, 32'h00924924);
        wr(8'h01, 32'h0);
        ret();
        wait_ack();
        wr(8'h02, 32'h0);
        ret();
        rd_chk("ipl restored", 8'h05, 32'h0);
    endtask
    task automatic s_hold();
        @(posedge clk) ack_en <= 1'b0;
        wr(8'h04, 32'h00924934);
        wr(8'h03, 32'h2);
        ev(8'h02, 4'h0);
        cyc(3);
        rd_chk("last acked", 8'h00, 32'h00008004);
        wr(8'h00, 32'h00002000);
        rd_chk("pending", 8'h00, 32'h0000a005);
        chk_req(1'b1, 4'h6);
        wr(8'h00, 32'h0);
    endtask
    task automatic s_mask();
        wr(8'h05, 32'he0);
        cyc(2);
        chk_req(1'b0, 4'h0);
        wr(8'h05, 32'hc0);
        cyc(2);
        chk_req(1'b0, 4'h0);
        wr(8'h05, 32'h0);
        cyc(2);
        chk_req(1'b1, 4'h6);
        wr(8'h06, 32'h14);
        cyc(2);
        chk_req(1'b0, 4'h0);
        wr(8'h04, 32'h0092493c);
        cyc(2);
        chk_req(1'b1, 4'h7);
        cyc(20);
        wr(8'h02, 32'h0);
        wr(8'h03, 32'h0);
    endtask
    task automatic s_trap();
        rd(8'h07, rdv);
        wr(8'h08, 32'h1);
        wr(8'h05, 32'he0);
        @(posedge clk) ack_en <= 1'b1;
        ev(8'h00, 4'h1);
        wait_ack();
        chk_req(1'b1, intc_pkg::LEVEL_TRAP_MIN);
        cyc(3);
        chk("irq raised", 32'(irq), 32'h1);
        rd(8'h07, rdv);
        chk("ack event", rdv & 32'h1, 32'h1);
        cyc(2);
        chk("irq cleared", 32'(irq), 32'h0);
        rd_chk("trap flag", 8'h01, 32'h1);
        ret();
        wait_ack();
        @(posedge clk) ack_en <= 1'b0;
        wr(8'h01, 32'h0);
        rd_chk("trap cleared", 8'h01, 32'h0);
        ret();
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {rst_n, bus_req, src_event, trap_event, ack_en, slow, ret_go} = '0;
        n_errors = 0;
        n_tests = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        s_reset();
        s_service();
        s_hold();
        s_mask();
        @(posedge clk) slow <= 1'b1;
        s_trap();
        tally_and_finish();
    end
endmodule
`default_nettype wire
